// ### pkg/phm_map.svh
// Purpose: Offsets, field codes, reset values and timing counts
// Assumes: 50 MHz system clock
// Notes:   Definitions only
`ifndef PHM_MAP_SVH
`define PHM_MAP_SVH

// ----------------------------------------------------------------
// Clock and soft-start timing
// ----------------------------------------------------------------
`define PHM_CLK_PERIOD_NS   20
`define PHM_SS_TIME_US      400
`define PHM_SS_CYCLES       ((`PHM_SS_TIME_US * 1000) / `PHM_CLK_PERIOD_NS)
`define PHM_SS_STEPS        64
`define PHM_SS_LVL_W        6

// ----------------------------------------------------------------
// Battery monitor, millivolts
// ----------------------------------------------------------------
`define PHM_BAT_BASE_MV     13'h09c4
`define PHM_BAT_STEP_MV     13'h0064
`define PHM_BAT_HYST_MV     13'h00c8
`define PHM_BAT_CODE_RST    4'h0

// ----------------------------------------------------------------
// Thermal levels, degrees C
// ----------------------------------------------------------------
`define PHM_TEMP_WARN_C     8'h78
`define PHM_TEMP_SHDN_C     8'ha0
`define PHM_TEMP_HYST_C     8'h14

// ----------------------------------------------------------------
// Configuration field selects
// ----------------------------------------------------------------
`define PHM_DEV_ADDR        7'h5a
`define PHM_SEL_BAT_CODE    4'h0
`define PHM_SEL_BAT_MASK    4'h1
`define PHM_SEL_TMP_MASK    4'h2
`define PHM_SEL_BUCK_EN     4'h3
`define PHM_SEL_BANK_A      2'h1
`define PHM_SEL_BANK_B      2'h2

`endif

// ### pkg/phm_pkg.sv
// Purpose: Shared types of the housekeeping monitor
// Assumes: Constants live in phm_map.svh
// Notes:   Types only
package phm_pkg;

  typedef logic [5:0] phm_vcode_t;

  typedef enum logic [2:0] {
    PHM_SS_OFF  = 3'b001,
    PHM_SS_RAMP = 3'b010,
    PHM_SS_ON   = 3'b100
  } phm_ss_state_e;

endpackage

// ### pkg/phm_ss_if.sv
// Purpose: Carrier between the monitor core and one soft-start unit
// Assumes: Single clock domain
// Notes:   One instance per step-down regulator
`timescale 1ns/10ps
interface phm_ss_if;
  logic       enable;
  logic       fault;
  logic       ramp_active;
  logic [5:0] ramp_level;

  modport core (
    output enable,
    output fault,
    input  ramp_active,
    input  ramp_level
  );

  modport unit (
    input  enable,
    input  fault,
    output ramp_active,
    output ramp_level
  );
endinterface

// ### logic/phm_softstart.sv
// Purpose: Soft-start ramp sequencer for one step-down regulator
// Assumes: step_en_i pulses once per ramp step
// Notes:   Ramp restarts after every enable and every fault recovery
`timescale 1ns/10ps
`include "phm_map.svh"
module phm_softstart
  import phm_pkg::*;
(
  input  wire logic sys_clk_i, // System clock
  input  wire logic resetn_i,  // Async reset, active low
  input  wire logic step_en_i, // Ramp step enable pulse
  phm_ss_if.unit    ss         // Link to core
);

  phm_ss_state_e                   state_q;
  phm_ss_state_e                   state_d;
  logic [`PHM_SS_LVL_W-1:0]        level_q;
  logic [`PHM_SS_LVL_W-1:0]        level_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    unique case (state_q)
      PHM_SS_OFF: begin
        level_d = '0;
        if (ss.enable && !ss.fault) begin
          state_d = PHM_SS_RAMP; // R8
        end
      end
      PHM_SS_RAMP: begin
        if (!ss.enable || ss.fault) begin
          state_d = PHM_SS_OFF;
        end else if (step_en_i) begin
          if (level_q == {`PHM_SS_LVL_W{1'b1}}) begin
            state_d = PHM_SS_ON;
          end else begin
            level_d = level_q + 1'b1;
          end
        end
      end
      PHM_SS_ON: begin
        // Fault drops to off so recovery ramps again
        if (!ss.enable || ss.fault) begin
          state_d = PHM_SS_OFF; // R8
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= PHM_SS_OFF;
      level_q <= '0;
    end else begin
      state_q <= state_d;
      level_q <= level_d;
    end
  end

  assign ss.ramp_active = (state_q == PHM_SS_RAMP);
  assign ss.ramp_level  = level_q;

endmodule

// ### logic/phm_top.sv
// Purpose: Battery monitor, thermal protection and buck control core
// Assumes: Battery and die temperature come from ADCs on sys_clk_i;
//          bank select and fault pins are asynchronous
// Notes:   Configuration arrives as decoded single-byte writes
`timescale 1ns/10ps
`include "phm_map.svh"

// Overview of operation
// (R1) Battery comparator off until threshold code written
// (R2) Threshold is 2.5 V plus 0.1 V per code
// (R3) Low flag clears 200 mV above falling threshold
// (R4) Battery low flag mirrors comparator output
// (R5) Low-battery interrupt only when unmasked, masked at reset
// (R6) Thermal warning at 120 C interrupts when unmasked
// (R7) Above 160 C all regulators off until 20 C cooler
// (R8) Soft-start ramp of 400 us on enable or recovery
// (R9) Bank select pin picks code bank for bucks 2-4
// (R10) Host writes the bank matching the select pin
// (R11) Bucks use factory default codes until rewritten
// (R12) Open-drain interrupt pulled low on unmasked condition
// (R13) Only slave address 1011010x with byte writes
// (R14) Masked sources ORed into single interrupt output
module phm_top
  import phm_pkg::*;
#(
  parameter int         SS_CYCLES  = `PHM_SS_CYCLES,
  parameter phm_vcode_t DEF_CODE_A = 6'h18,
  parameter phm_vcode_t DEF_CODE_B = 6'h18
) (
  input  wire logic             sys_clk_i,          // System clock
  input  wire logic             resetn_i,           // Async reset, low
  input  wire logic             cfg_wr_i,           // Write strobe
  input  wire logic [7:0]       cfg_addr_i,         // Slave address byte
  input  wire logic [3:0]       cfg_sel_i,          // Field select
  input  wire logic [7:0]       cfg_data_i,         // Write data
  input  wire logic             battery_sense_vld_i,// Battery sample valid
  input  wire logic [12:0]      battery_sense_input_i, // Battery, mV
  input  wire logic             die_temp_vld_i,     // Temp sample valid
  input  wire logic [7:0]       die_temp_i,         // Die temp, deg C
  input  wire logic             voltage_bank_select_i, // Bank pin
  input  wire logic [3:0]       buck_fault_i,       // Fault pins
  output logic                  battery_low_flag_o, // Battery low
  output logic                  thermal_warn_o,     // Temp warning
  output logic                  thermal_shutdown_o, // Shutdown active
  output logic [3:0]            buck_on_o,          // Regulator on
  output logic [3:0]            buck_ss_active_o,   // Ramp running
  output phm_vcode_t [3:0]      buck_vcode_o,       // Active codes
  output logic                  interrupt_out_n_o,  // Pin level, low
  output logic                  interrupt_oe_o      // Pin drive enable
);

  localparam int SS_STEP_CYC = SS_CYCLES / `PHM_SS_STEPS;

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [3:0]       bat_code_q;
  logic [3:0]       bat_code_d;
  logic             bat_mon_en_q;
  logic             bat_mon_en_d;
  logic             bat_unmask_q;
  logic             bat_unmask_d;
  logic             tmp_unmask_q;
  logic             tmp_unmask_d;
  logic [3:0]       buck_en_q;
  logic [3:0]       buck_en_d;
  phm_vcode_t [3:0] bank_a_q;
  phm_vcode_t [3:0] bank_a_d;
  phm_vcode_t [3:0] bank_b_q;
  phm_vcode_t [3:0] bank_b_d;
  logic             wr_ok;

  always_comb begin
    bat_code_d   = bat_code_q;
    bat_mon_en_d = bat_mon_en_q;
    bat_unmask_d = bat_unmask_q;
    tmp_unmask_d = tmp_unmask_q;
    buck_en_d    = buck_en_q;
    bank_a_d     = bank_a_q;
    bank_b_d     = bank_b_q;
    // Foreign addresses and read bytes never touch state
    wr_ok = cfg_wr_i && (cfg_addr_i[7:1] == `PHM_DEV_ADDR) &&
            !cfg_addr_i[0]; // R13
    if (wr_ok) begin
      if (cfg_sel_i == `PHM_SEL_BAT_CODE) begin
        bat_code_d   = cfg_data_i[3:0];
        bat_mon_en_d = 1'b1; // R1
      end
      if (cfg_sel_i == `PHM_SEL_BAT_MASK) begin
        bat_unmask_d = cfg_data_i[0];
      end
      if (cfg_sel_i == `PHM_SEL_TMP_MASK) begin
        tmp_unmask_d = cfg_data_i[0];
      end
      if (cfg_sel_i == `PHM_SEL_BUCK_EN) begin
        buck_en_d = cfg_data_i[3:0];
      end
      if (cfg_sel_i[3:2] == `PHM_SEL_BANK_A) begin
        bank_a_d[cfg_sel_i[1:0]] = cfg_data_i[5:0]; // R11
      end
      // Buck one has no second bank
      if (cfg_sel_i[3:2] == `PHM_SEL_BANK_B &&
          cfg_sel_i[1:0] != 2'h0) begin
        bank_b_d[cfg_sel_i[1:0]] = cfg_data_i[5:0]; // R10
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bat_code_q   <= `PHM_BAT_CODE_RST;
      bat_mon_en_q <= 1'b0; // R1
      bat_unmask_q <= 1'b0; // R5
      tmp_unmask_q <= 1'b0;
      buck_en_q    <= 4'h0;
      bank_a_q     <= {4{DEF_CODE_A}}; // R11
      bank_b_q     <= {4{DEF_CODE_B}}; // R11
    end else begin
      bat_code_q   <= bat_code_d;
      bat_mon_en_q <= bat_mon_en_d;
      bat_unmask_q <= bat_unmask_d;
      tmp_unmask_q <= tmp_unmask_d;
      buck_en_q    <= buck_en_d;
      bank_a_q     <= bank_a_d;
      bank_b_q     <= bank_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 4 is the bank select pin, bits 3:0 the fault pins
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [4:0] pin_q;
  logic [4:0] pin_d;

  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i < 5; i++) begin
      if (pin_s2_q[i] == pin_s3_q[i]) begin
        pin_d[i] = pin_s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
      pin_q    <= 5'h00;
    end else begin
      pin_s1_q <= {voltage_bank_select_i, buck_fault_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Battery comparator
  // ----------------------------------------------------------------
  logic [12:0] bat_fall_mv;
  logic [12:0] bat_rise_mv;
  logic        bat_low_q;
  logic        bat_low_d;

  always_comb begin
    bat_fall_mv = `PHM_BAT_BASE_MV +
                  13'(`PHM_BAT_STEP_MV * {9'h000, bat_code_q}); // R2
    bat_rise_mv = bat_fall_mv + `PHM_BAT_HYST_MV; // R3
    bat_low_d   = bat_low_q;
    if (!bat_mon_en_q) begin
      bat_low_d = 1'b0; // R1
    end else if (battery_sense_vld_i) begin
      if (battery_sense_input_i < bat_fall_mv) begin
        bat_low_d = 1'b1; // R4
      end else if (battery_sense_input_i >= bat_rise_mv) begin
        bat_low_d = 1'b0; // R3
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bat_low_q <= 1'b0;
    end else begin
      bat_low_q <= bat_low_d;
    end
  end

  // ----------------------------------------------------------------
  // Thermal warning and shutdown
  // ----------------------------------------------------------------
  logic warn_q;
  logic warn_d;
  logic tsd_q;
  logic tsd_d;

  always_comb begin
    warn_d = warn_q;
    tsd_d  = tsd_q;
    if (die_temp_vld_i) begin
      warn_d = (die_temp_i >= `PHM_TEMP_WARN_C); // R6
      if (die_temp_i > `PHM_TEMP_SHDN_C) begin
        tsd_d = 1'b1; // R7
      end else if (die_temp_i <=
                   (`PHM_TEMP_SHDN_C - `PHM_TEMP_HYST_C)) begin
        tsd_d = 1'b0; // R7
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warn_q <= 1'b0;
      tsd_q  <= 1'b0;
    end else begin
      warn_q <= warn_d;
      tsd_q  <= tsd_d;
    end
  end

  // ----------------------------------------------------------------
  // Soft-start step divider and regulator units
  // ----------------------------------------------------------------
  logic [15:0] step_cnt_q;
  logic [15:0] step_cnt_d;
  logic        step_en;

  always_comb begin
    step_en    = (step_cnt_q == 16'(SS_STEP_CYC - 1));
    step_cnt_d = step_en ? 16'h0000 : step_cnt_q + 16'h0001;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_cnt_q <= 16'h0000;
    end else begin
      step_cnt_q <= step_cnt_d;
    end
  end

  logic [3:0] ss_active;

  for (genvar g = 0; g < 4; g++) begin : g_buck
    phm_ss_if ss_link ();
    // Shutdown forces every regulator off
    assign ss_link.enable = buck_en_q[g] && !tsd_q; // R7
    assign ss_link.fault  = pin_q[g];
    assign ss_active[g]   = ss_link.ramp_active;
    phm_softstart phm_softstart_inst (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .step_en_i (step_en),
      .ss        (ss_link)
    );
  end

  // ----------------------------------------------------------------
  // Voltage code selection
  // ----------------------------------------------------------------
  phm_vcode_t [3:0] vcode_d;

  always_comb begin
    vcode_d[0] = bank_a_q[0];
    for (int i = 1; i < 4; i++) begin
      vcode_d[i] = pin_q[4] ? bank_b_q[i] : bank_a_q[i]; // R9
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and status outputs
  // ----------------------------------------------------------------
  logic irq_d;

  always_comb begin
    irq_d = (bat_low_q && bat_unmask_q) || // R5
            (warn_q && tmp_unmask_q);      // R6 R14
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      battery_low_flag_o <= 1'b0;
      thermal_warn_o     <= 1'b0;
      thermal_shutdown_o <= 1'b0;
      buck_on_o          <= 4'h0;
      buck_ss_active_o   <= 4'h0;
      buck_vcode_o       <= {4{DEF_CODE_A}};
      interrupt_out_n_o  <= 1'b0;
      interrupt_oe_o     <= 1'b0;
    end else begin
      battery_low_flag_o <= bat_low_q; // R4
      thermal_warn_o     <= warn_q;
      thermal_shutdown_o <= tsd_q;
      buck_on_o          <= buck_en_q & {4{!tsd_q}}; // R7
      buck_ss_active_o   <= ss_active; // R8
      buck_vcode_o       <= vcode_d;
      // Open drain: only ever pulls low
      interrupt_out_n_o  <= 1'b0;
      interrupt_oe_o     <= irq_d; // R12
    end
  end

endmodule

// ### testbench/phm_top_properties.sv
// Purpose: Port-level assertions for the housekeeping monitor
// Assumes: One clock, async active-low reset
// Notes:   Bound to phm_top from the bench file
`timescale 1ns/10ps
module phm_top_properties (
  input wire logic       sys_clk_i,           // Clock
  input wire logic       resetn_i,            // Reset, low
  input wire logic       battery_sense_vld_i, // Battery valid
  input wire logic       die_temp_vld_i,      // Temp valid
  input wire logic [7:0] die_temp_i,          // Temp, deg C
  input wire logic [3:0] buck_fault_i,        // Fault pins
  input wire logic       battery_low_flag_o,  // Battery low
  input wire logic       thermal_warn_o,      // Warning
  input wire logic       thermal_shutdown_o,  // Shutdown
  input wire logic [3:0] buck_on_o,           // Regulator on
  input wire logic [3:0] buck_ss_active_o,    // Ramp running
  input wire logic       interrupt_out_n_o,   // Pin level
  input wire logic       interrupt_oe_o       // Pin drive
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_irq_src;
    interrupt_oe_o |-> battery_low_flag_o || thermal_warn_o;
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq without source");
  property p_pin_low;
    interrupt_out_n_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("pin value not low");
  property p_warn_on;
    die_temp_vld_i && die_temp_i >= 8'h78 |-> ##2 thermal_warn_o;
  endproperty
  a_warn_on: assert property (p_warn_on)
    else $error("warning missed");
  property p_warn_off;
    die_temp_vld_i && die_temp_i < 8'h78 |-> ##2 !thermal_warn_o;
  endproperty
  a_warn_off: assert property (p_warn_off)
    else $error("false warning");
  property p_tsd_set;
    die_temp_vld_i && die_temp_i > 8'ha0 |-> ##2 thermal_shutdown_o;
  endproperty
  a_tsd_set: assert property (p_tsd_set)
    else $error("shutdown missed");
  property p_tsd_rise;
    $rose(thermal_shutdown_o) |->
      $past(die_temp_vld_i, 2) && $past(die_temp_i, 2) > 8'ha0;
  endproperty
  a_tsd_rise: assert property (p_tsd_rise)
    else $error("early shutdown");
  property p_tsd_fall;
    $fell(thermal_shutdown_o) |->
      $past(die_temp_vld_i, 2) && $past(die_temp_i, 2) <= 8'h8c;
  endproperty
  a_tsd_fall: assert property (p_tsd_fall)
    else $error("early release");
  property p_tsd_off;
    thermal_shutdown_o |-> buck_on_o == 4'h0;
  endproperty
  a_tsd_off: assert property (p_tsd_off)
    else $error("buck on in shutdown");
  property p_flag_src;
    $changed(battery_low_flag_o) |-> $past(battery_sense_vld_i, 2);
  endproperty
  a_flag_src: assert property (p_flag_src)
    else $error("flag without sample");
  property p_ss_start;
    $rose(buck_on_o[0]) && !buck_fault_i[0] |-> ##[1:4] buck_ss_active_o[0];
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("no soft-start");
endmodule

// ### testbench/phm_host_model.sv
// Purpose: Host side issuing decoded single-byte configuration writes
// Assumes: Drives on the falling clock edge
// Notes:   Released fields show inverted values, never a stale copy
`timescale 1ns/10ps
module phm_host_model (
  input  wire logic       sys_clk_i,  // Clock
  output logic            cfg_wr_o,   // Write strobe
  output logic [7:0]      cfg_addr_o, // Address byte
  output logic [3:0]      cfg_sel_o,  // Field select
  output logic [7:0]      cfg_data_o  // Data byte
);
  initial begin
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_sel_o = 4'h0;
    cfg_data_o = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [7:0] d);
    @(negedge sys_clk_i);
    cfg_wr_o = 1'b1;
    cfg_addr_o = a;
    cfg_sel_o = s;
    cfg_data_o = d;
    @(negedge sys_clk_i);
    cfg_wr_o = 1'b0;
    cfg_addr_o = ~a;
    cfg_sel_o = ~s;
    cfg_data_o = ~d;
  endtask

  // Bank chosen from the pin level the host believes is applied
  task automatic prog(input int lane, input logic [5:0] code,
                      input logic pin);
    wr(8'hb4, (pin && lane != 0) ? 4'(8 + lane) : 4'(4 + lane),
       {2'h0, code});
  endtask
endmodule

// ### testbench/phm_top_bench.sv
// Purpose: Self-checking bench for the housekeeping monitor
// Assumes: 50 MHz clock, inputs changed on the falling edge
// Notes:   Short soft-start (640 cycles) keeps the run brief
`timescale 1ns/10ps
module phm_top_bench;
  import phm_pkg::*;
  logic sys_clk_i, resetn, svld, tvld, bank, flag, warn, tsd, oe, pin_n;
  logic wr;
  logic [7:0] addr, data, temp;
  logic [3:0] sel, fault, on, ss;
  logic [12:0] sense, thr;
  phm_vcode_t [3:0] vcode;
  int err_total = 0;
  int checks = 0;

  phm_host_model phm_host_model_inst (.sys_clk_i(sys_clk_i), .cfg_wr_o(wr),
    .cfg_addr_o(addr), .cfg_sel_o(sel), .cfg_data_o(data));
  phm_top #(.SS_CYCLES(640), .DEF_CODE_A(6'h11), .DEF_CODE_B(6'h22))
    phm_top_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_sel_i(sel), .cfg_data_i(data),
    .battery_sense_vld_i(svld), .battery_sense_input_i(sense),
    .die_temp_vld_i(tvld), .die_temp_i(temp), .voltage_bank_select_i(bank),
    .buck_fault_i(fault), .battery_low_flag_o(flag), .thermal_warn_o(warn),
    .thermal_shutdown_o(tsd), .buck_on_o(on), .buck_ss_active_o(ss),
    .buck_vcode_o(vcode), .interrupt_out_n_o(pin_n), .interrupt_oe_o(oe));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bat(input logic [12:0] mv);
    @(negedge sys_clk_i);
    svld = 1'b1;
    sense = mv;
    @(negedge sys_clk_i);
    svld = 1'b0;
    sense = ~mv;
    cyc(3);
  endtask
  task automatic tmp(input logic [7:0] t);
    @(negedge sys_clk_i);
    tvld = 1'b1;
    temp = t;
    @(negedge sys_clk_i);
    tvld = 1'b0;
    temp = ~t;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    wrap_up();
  end

  initial begin
    {resetn, svld, tvld, bank, fault, sense, temp} = '0;
    cyc(2);
    resetn = 1'b1;
    cyc(2);
    chk(vcode, {4{6'h11}});
    bat(13'h07d0);
    chk(flag, 1'b0);
    for (int c = 0; c < 16; c++) begin
      thr = 13'(2500 + 100 * c);
      phm_host_model_inst.wr(8'hb4, 4'h0, 8'(c));
      bat(thr);
      chk(flag, 1'b0);
      bat(thr - 13'h1);
      chk(flag, 1'b1);
      bat(thr + 13'h0c7);
      chk(flag, 1'b1);
      bat(thr + 13'h0c8);
      chk(flag, 1'b0);
    end
    bat(13'h0bb8);
    chk(oe, 1'b0);
    phm_host_model_inst.wr(8'hb4, 4'h1, 8'h01);
    cyc(3);
    chk({pin_n, oe}, 2'b01);
    phm_host_model_inst.wr(8'hb4, 4'h1, 8'h00);
    cyc(3);
    chk(oe, 1'b0);
    bat(13'h1068);
    phm_host_model_inst.wr(8'hb4, 4'h2, 8'h01);
    tmp(8'h77);
    chk({warn, oe}, 2'b00);
    tmp(8'h78);
    chk({warn, oe}, 2'b11);
    tmp(8'h64);
    chk(oe, 1'b0);
    // Wrong address, read bit, refused selects leave codes alone
    phm_host_model_inst.wr(8'hb5, 4'h4, 8'h3f);
    phm_host_model_inst.wr(8'hb6, 4'h4, 8'h3f);
    phm_host_model_inst.wr(8'hb4, 4'h8, 8'h3f);
    phm_host_model_inst.wr(8'hb4, 4'hc, 8'h3f);
    cyc(3);
    chk(vcode, {4{6'h11}});
    for (int i = 0; i < 4; i++)
      phm_host_model_inst.prog(i, 6'(6'h20 + i), bank);
    cyc(3);
    chk(vcode, {6'h23, 6'h22, 6'h21, 6'h20});
    bank = 1'b1;
    cyc(8);
    chk(vcode, {6'h22, 6'h22, 6'h22, 6'h20});
    for (int i = 1; i < 4; i++)
      phm_host_model_inst.prog(i, 6'(6'h30 + i), bank);
    cyc(3);
    chk(vcode, {6'h33, 6'h32, 6'h31, 6'h20});
    bank = 1'b0;
    cyc(8);
    chk(vcode, {6'h23, 6'h22, 6'h21, 6'h20});
    phm_host_model_inst.wr(8'hb4, 4'h3, 8'h0f);
    cyc(5);
    chk({on, ss}, 8'hff);
    cyc(580);
    chk(ss, 4'hf);
    cyc(80);
    chk(ss, 4'h0);
    fault = 4'h2;
    cyc(8);
    chk(ss[1], 1'b0);
    fault = 4'h0;
    cyc(8);
    chk(ss[1], 1'b1);
    tmp(8'ha0);
    chk(tsd, 1'b0);
    tmp(8'ha1);
    chk({tsd, on}, 5'h10);
    tmp(8'h8d);
    chk(tsd, 1'b1);
    phm_host_model_inst.wr(8'hb4, 4'h3, 8'h0f);
    cyc(3);
    chk(on, 4'h0);
    tmp(8'h8c);
    chk(tsd, 1'b0);
    cyc(3);
    chk({on, ss}, 8'hff);
    wrap_up();
  end
endmodule

bind phm_top phm_top_properties phm_top_properties_inst (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .battery_sense_vld_i(battery_sense_vld_i),
  .die_temp_vld_i(die_temp_vld_i), .die_temp_i(die_temp_i),
  .buck_fault_i(buck_fault_i), .battery_low_flag_o(battery_low_flag_o),
  .thermal_warn_o(thermal_warn_o), .thermal_shutdown_o(thermal_shutdown_o),
  .buck_on_o(buck_on_o), .buck_ss_active_o(buck_ss_active_o),
  .interrupt_out_n_o(interrupt_out_n_o), .interrupt_oe_o(interrupt_oe_o));
